// ==== rtl/tmdp_pkg.sv ====
package tmdp_pkg;
  // Register addresses on the seven-bit programming address
  localparam logic [6:0] ADDR_STATE_AMP = 7'h00;
  localparam logic [6:0] ADDR_FILTER_IND = 7'h01;
  localparam logic [6:0] ADDR_BITCLK_SCALE = 7'h06;
  localparam logic [6:0] ADDR_REF_DIV = 7'h07;
  localparam logic [6:0] ADDR_CHFILT_DIV = 7'h08;
  // Reset values
  localparam logic [7:0] RST_STATE_AMP = 8'h01;
  localparam logic [7:0] RST_FILTER_IND = 8'h80;
  localparam logic [7:0] RST_BITCLK_SCALE = 8'h00;
  localparam logic [7:0] RST_REF_DIV = 8'h01;
  localparam logic [7:0] RST_CHFILT_DIV = 8'h41;
  // Writable masks and fixed read values
  localparam logic [7:0] WMASK_STATE_AMP = 8'hfe;
  localparam logic [7:0] FIX_STATE_AMP = 8'h01;
  localparam logic [7:0] WMASK_FILTER_IND = 8'h0f;
  localparam logic [7:0] FIX_FILTER_IND = 8'h80;
  localparam logic [7:0] WMASK_BITCLK_SCALE = 8'h0f;
  localparam logic [7:0] FIX_BITCLK_SCALE = 8'h00;
  localparam logic [7:0] WMASK_CHFILT_DIV = 8'hbf;
  localparam logic [7:0] FIX_CHFILT_DIV = 8'h40;
  // Field positions, state and amp control
  localparam int STATE_LO_BIT = 1;
  localparam int STATE_HI_BIT = 2;
  localparam int SYNC_EN_BIT = 3;
  localparam int AMP_LEVEL_LSB = 4;
  localparam int FRONT_BYP_BIT = 7;
  // Filter and indicator control
  localparam int PF_CUT_LSB = 0;
  localparam int LOCK_EN_BIT = 2;
  localparam int LEVEL_EN_BIT = 3;
  // Bit clock scale, reference divider, channel filter divider
  localparam int RESYNC_SCALE_LSB = 1;
  localparam int BITRATE_SCALE_HI_BIT = 0;
  localparam int BITRATE_SCALE_LO_LSB = 6;
  localparam int REF_DIV_LSB = 0;
  localparam int CHFILT_DIV_LSB = 0;
  localparam int CHFILT_BYP_BIT = 7;
  // Clock exponent and scale limits
  localparam logic [2:0] CLK_EXP = 3'h7;
  localparam logic [2:0] BITRATE_SCALE_MAX = 3'h6;
  // Bit synchronizer oversampling phases
  localparam logic [3:0] PH_SAMPLE = 4'h7;
  localparam logic [3:0] PH_LAST = 4'hf;
  localparam int CNT_W = 13;
  typedef enum logic [1:0] {
    ST_POWER_DOWN,
    ST_STANDBY,
    ST_RECEIVE,
    ST_TRANSMIT
  } tmdp_state_type;
endpackage

// ==== rtl/tmdp_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmdp_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output tmdp_pkg::tmdp_state_type radio_state,
  output logic front_amp_bypass,
  output logic [1:0] prefilter_cutoff,
  output logic channel_filter_bypass,
  output logic channel_filter_clk_en,
  output logic pa_enable,
  output logic [2:0] amp_level,
  output logic signal_level_enable,
  output logic lock_detect_enable,
  input wire logic demod_data,
  output logic tx_mod_data,
  input wire logic data_line_in,
  output logic data_line_out,
  output logic data_line_oe,
  output logic data_bit_clock
);
  import tmdp_pkg::*;

  // Every register and counter lives in one record
  typedef struct packed {
    logic [7:0] r_state;
    logic [7:0] r_filt;
    logic [7:0] r_scale;
    logic [7:0] r_ref;
    logic [7:0] r_chdiv;
    logic [7:0] rdata;
    logic [CNT_W-1:0] rate_cnt;
    logic [CNT_W-1:0] sync_cnt;
    logic [3:0] phase;
    logic prev_raw;
    logic dclk;
    logic rxd;
    logic txd;
    logic [5:0] ch_cnt;
    logic ch_en;
    logic sync_prev;
    logic dir_prev;
  } tmdp_regs_type;

  tmdp_regs_type s_r, s_nxt;

  // Divide count K*2^(exp-S); scale clamped so shift stays non-negative
  // Thirteen count bits hold the largest product, 63 times 128
  function automatic logic [CNT_W-1:0] div_count(input logic [5:0] k, input logic [2:0] s,
                                                 input logic [2:0] e);
    logic [2:0] sh;
    logic [5:0] kk;
    sh = (s > e) ? 3'h0 : 3'(e - s);
    kk = (k == 6'h00) ? 6'h01 : k;
    div_count = CNT_W'({7'h00, kk} << sh);
  endfunction

  // Decoded fields and derived counts
  logic [1:0] mode;
  logic sync_en;
  logic [5:0] ref_k;
  logic [2:0] rate_s;
  logic [2:0] resync_s;
  logic [CNT_W-1:0] half_rate;
  logic [CNT_W-1:0] tick_rate;
  logic [5:0] ch_div;
  logic sync_active;
  logic restart;

  // Field decode
  assign mode = {s_r.r_state[STATE_HI_BIT], s_r.r_state[STATE_LO_BIT]};
  assign sync_en = s_r.r_state[SYNC_EN_BIT];
  assign ref_k = s_r.r_ref[REF_DIV_LSB +: 6];
  assign rate_s = {s_r.r_scale[BITRATE_SCALE_HI_BIT], s_r.r_ref[BITRATE_SCALE_LO_LSB +: 2]};
  assign resync_s = s_r.r_scale[RESYNC_SCALE_LSB +: 3];
  // Half a bit-rate period per toggle gives even high and low phases
  assign half_rate = div_count(ref_k, rate_s, CLK_EXP - 3'h1);
  assign tick_rate = div_count(ref_k, resync_s, CLK_EXP);
  assign ch_div = s_r.r_chdiv[CHFILT_DIV_LSB +: 6];
  assign sync_active = sync_en && mode[1];
  // Restart on enable and on a receive/transmit swap; no stale phase carries over
  assign restart = !sync_active || !s_r.sync_prev || (mode[0] != s_r.dir_prev);

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.ch_en = 1'b0;
    // Register writes; fixed bits stay at their constant value
    if (reg_wr) begin
      case (reg_addr)
        ADDR_STATE_AMP: s_nxt.r_state = (reg_wdata & WMASK_STATE_AMP) | FIX_STATE_AMP;
        ADDR_FILTER_IND: s_nxt.r_filt = (reg_wdata & WMASK_FILTER_IND) | FIX_FILTER_IND;
        ADDR_BITCLK_SCALE: s_nxt.r_scale = (reg_wdata & WMASK_BITCLK_SCALE) | FIX_BITCLK_SCALE;
        ADDR_REF_DIV: s_nxt.r_ref = reg_wdata;
        ADDR_CHFILT_DIV: s_nxt.r_chdiv = (reg_wdata & WMASK_CHFILT_DIV) | FIX_CHFILT_DIV;
        default: ;
      endcase
    end
    // Read-back; unmapped addresses read zero
    case (reg_addr)
      ADDR_STATE_AMP: s_nxt.rdata = s_r.r_state;
      ADDR_FILTER_IND: s_nxt.rdata = s_r.r_filt;
      ADDR_BITCLK_SCALE: s_nxt.rdata = s_r.r_scale;
      ADDR_REF_DIV: s_nxt.rdata = s_r.r_ref;
      ADDR_CHFILT_DIV: s_nxt.rdata = s_r.r_chdiv;
      default: s_nxt.rdata = 8'h00;
    endcase
    // Channel filter clock enable; divider zero behaves as one
    // Compared with the live divider, so a rewrite acts at once
    if (s_r.ch_cnt + 6'h01 >= ch_div) begin
      s_nxt.ch_cnt = 6'h00;
      s_nxt.ch_en = 1'b1;
    end else begin
      s_nxt.ch_cnt = s_r.ch_cnt + 6'h01;
    end
    s_nxt.sync_prev = sync_active;
    s_nxt.dir_prev = mode[0];
    if (restart) begin
      // Idle, just enabled or receive/transmit swapped: counters restart, clock pin low
      s_nxt.rate_cnt = '0;
      s_nxt.sync_cnt = '0;
      s_nxt.phase = 4'h0;
      s_nxt.dclk = 1'b0;
      s_nxt.prev_raw = demod_data;
      // Transparent data paths follow the pins each cycle
      s_nxt.rxd = demod_data;
      s_nxt.txd = data_line_in;
    end else if (mode == 2'b11) begin
      // Synchronous transmit: device is clock master
      // Data taken on the rising half only, after the host moved it on the fall
      if (s_r.rate_cnt + CNT_W'(1) >= half_rate) begin
        s_nxt.rate_cnt = '0;
        s_nxt.dclk = ~s_r.dclk;
        if (!s_r.dclk) begin
          s_nxt.txd = data_line_in;
        end
      end else begin
        s_nxt.rate_cnt = s_r.rate_cnt + CNT_W'(1);
      end
    end else begin
      // Synchronous receive: sixteen ticks per bit, realign on edges
      // A data edge restarts the phase count and drops the clock at once
      if (s_r.sync_cnt + CNT_W'(1) >= tick_rate) begin
        s_nxt.sync_cnt = '0;
        s_nxt.prev_raw = demod_data;
        if (demod_data != s_r.prev_raw) begin
          s_nxt.phase = 4'h0;
        end else begin
          s_nxt.phase = s_r.phase + 4'h1;
        end
        if (s_r.phase == PH_SAMPLE && demod_data == s_r.prev_raw) begin
          // Data and rising clock move together, mid-bit sample
          s_nxt.rxd = demod_data;
          s_nxt.dclk = 1'b1;
        end else if (s_r.phase == PH_LAST || demod_data != s_r.prev_raw) begin
          s_nxt.dclk = 1'b0;
        end
      end else begin
        s_nxt.sync_cnt = s_r.sync_cnt + CNT_W'(1);
      end
    end
  end

  // State register
  // Synchronous reset loads the register defaults and clears counters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.r_state <= RST_STATE_AMP;
      s_r.r_filt <= RST_FILTER_IND;
      s_r.r_scale <= RST_BITCLK_SCALE;
      s_r.r_ref <= RST_REF_DIV;
      s_r.r_chdiv <= RST_CHFILT_DIV;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign reg_rdata = s_r.rdata;
  assign radio_state = tmdp_state_type'(mode);
  assign front_amp_bypass = s_r.r_state[FRONT_BYP_BIT];
  assign prefilter_cutoff = s_r.r_filt[PF_CUT_LSB +: 2];
  // Indicator enables pass straight to their blocks
  assign signal_level_enable = s_r.r_filt[LEVEL_EN_BIT];
  assign lock_detect_enable = s_r.r_filt[LOCK_EN_BIT];
  assign channel_filter_bypass = s_r.r_chdiv[CHFILT_BYP_BIT];
  assign channel_filter_clk_en = s_r.ch_en;
  assign amp_level = s_r.r_state[AMP_LEVEL_LSB +: 3];
  // Amplifier only powered while transmitting at a nonzero level
  assign pa_enable = (mode == 2'b11) && (amp_level != 3'h0);
  // Data pins; the line is driven only while receiving
  assign tx_mod_data = s_r.txd;
  assign data_line_out = s_r.rxd;
  assign data_line_oe = (mode == 2'b10);
  assign data_bit_clock = s_r.dclk;
endmodule
`default_nettype wire

// ==== bench/tmdp_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port checks of the mode and data port
module tmdp_chk import tmdp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire tmdp_pkg::tmdp_state_type radio_state,
  input wire logic front_amp_bypass,
  input wire logic [1:0] prefilter_cutoff,
  input wire logic channel_filter_bypass,
  input wire logic pa_enable,
  input wire logic [2:0] amp_level,
  input wire logic demod_data,
  input wire logic tx_mod_data,
  input wire logic data_line_in,
  input wire logic data_line_out,
  input wire logic data_line_oe,
  input wire logic data_bit_clock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A register write taken at this edge
  sequence wr_at(logic [6:0] a);
    reg_wr && reg_addr == a;
  endsequence
  state_set_a: assert property (wr_at(ADDR_STATE_AMP) |=>
    radio_state == $past(reg_wdata[2:1]) && front_amp_bypass == $past(reg_wdata[7]))
    else $error("state or bypass not taken from write");
  prefilt_set_a: assert property (wr_at(ADDR_FILTER_IND) |=>
    prefilter_cutoff == $past(reg_wdata[1:0])) else $error("cutoff code not taken");
  chf_bypass_a: assert property (wr_at(ADDR_CHFILT_DIV) |=>
    channel_filter_bypass == $past(reg_wdata[7])) else $error("filter bypass not taken");
  pa_off_a: assert property (pa_enable ==
    (radio_state == ST_TRANSMIT && amp_level != 3'h0)) else $error("amplifier enable wrong");
  line_dir_a: assert property (data_line_oe == (radio_state == ST_RECEIVE))
    else $error("data pin direction wrong");
  // One cycle allowed for the registered clock pin to settle
  clk_idle_a: assert property ((radio_state inside {ST_POWER_DOWN, ST_STANDBY})[*2]
    |-> !data_bit_clock) else $error("data clock active while idle");
  tx_sample_a: assert property (radio_state == ST_TRANSMIT && $rose(data_bit_clock)
    |-> tx_mod_data == $past(data_line_in)) else $error("tx data not sampled on rise");
  rx_present_a: assert property (radio_state == ST_RECEIVE && $rose(data_bit_clock)
    |-> data_line_out == $past(demod_data)) else $error("rx data not updated on rise");
endmodule
`default_nettype wire

// ==== bench/tmdp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host at the data pin; it has no timing of its own
module tmdp_host (
  input wire logic data_bit_clock,
  input wire logic data_line_out,
  input wire logic data_line_oe,
  input wire logic kick,
  output logic host_d,
  output logic rx_bit
);
  logic [7:0] sh = 8'h25;
  // Pin level is the low bit of the host's pattern register
  assign host_d = sh[0];
  // New bit on falling clock, or on a bench kick in transparent use
  always @(negedge data_bit_clock or kick) begin
    sh = {sh[6:0], sh[7] ^ sh[5] ^ sh[4] ^ sh[3]};
  end
  // Sample only while the device drives the pin
  always @(negedge data_bit_clock) begin
    if (data_line_oe) rx_bit = data_line_out;
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmdp_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, demod_data = 1'b0, kick = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, rnd = 8'h25, reg_rdata, m [0:8];
  logic [6:0] ad [6] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h08, 7'h02};
  tmdp_state_type radio_state;
  logic front_amp_bypass, channel_filter_bypass, channel_filter_clk_en, pa_enable;
  logic signal_level_enable, lock_detect_enable, tx_mod_data, data_line_out;
  logic data_line_oe, data_bit_clock, host_d, rx_bit, data_line_in;
  logic [1:0] prefilter_cutoff;
  logic [2:0] amp_level;
  int fails = 0, compares = 0;
  // Pin level: device drives in receive, host otherwise
  assign data_line_in = data_line_oe ? data_line_out : host_d;
  always #25 core_clk = ~core_clk;
  tmdp_core tmdp_core_inst (.*);
  tmdp_host tmdp_host_inst (.*);
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Writable bits; unmapped places take nothing
  function automatic logic [7:0] wm(input logic [6:0] a);
    case (a)
      ADDR_STATE_AMP: return WMASK_STATE_AMP;
      ADDR_FILTER_IND: return WMASK_FILTER_IND;
      ADDR_BITCLK_SCALE: return WMASK_BITCLK_SCALE;
      ADDR_REF_DIV: return 8'hff;
      ADDR_CHFILT_DIV: return WMASK_CHFILT_DIV;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic sg(input bit w);
    return w ? channel_filter_clk_en : data_bit_clock;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Inputs always move 2 ns after the edge
  task automatic cyc();
    @(posedge core_clk);
    #2;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    m[a] = (d & wm(a)) | (m[a] & ~wm(a));
    cyc();
    reg_wr = 1'b0;
    // Let an edge pass so a following write never re-raises the strobe at once
    cyc();
  endtask
  task automatic rd(input logic [6:0] a);
    reg_addr = a;
    cyc();
    chk(reg_rdata, m[a]);
  endtask
  // Cycles between two rises; a dead clock ends the run
  task automatic gap(input bit w, input int exp);
    int n, s;
    n = 0;
    s = 0;
    for (int p = 0; p < 4; p++) begin
      if (p == 2) s = n;
      while (sg(w) === !p[0]) begin
        cyc();
        n++;
        if (n > 900) begin
          fails++;
          end_of_test();
        end
      end
    end
    chk(8'(n - s), 8'(exp));
  endtask
  initial begin
    m = '{RST_STATE_AMP, RST_FILTER_IND, 8'h00, 8'h00, 8'h00, 8'h00,
      RST_BITCLK_SCALE, RST_REF_DIV, RST_CHFILT_DIV};
    repeat (12) cyc();
    rst = 1'b0;
    // Reset values, then random writes read back
    foreach (ad[i]) rd(ad[i]);
    for (int j = 0; j < 12; j++) begin
      rnd = nx(rnd);
      wr(ad[j % 6], rnd);
      rd(ad[j % 6]);
      chk({front_amp_bypass, amp_level, 4'h0}, m[0] & 8'hf0);
      chk(8'({signal_level_enable, lock_detect_enable, prefilter_cutoff}), m[1] & 8'h0f);
      chk(8'(channel_filter_bypass), 8'(m[8][7]));
    end
    $display("registers done");
    // Every state, amplifier level zero and nonzero, sync off
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_STATE_AMP, {1'b0, i[2] ? 3'h5 : 3'h0, 1'b0, i[1:0], 1'b1});
      chk(8'(radio_state), 8'(i[1:0]));
      chk(8'(pa_enable), 8'(i == 7));
      chk(8'(data_line_oe), 8'(i[1:0] == 2'h2));
      chk(8'(data_bit_clock), 8'h00);
    end
    // Transparent transmit, then transparent receive, one cycle late
    for (int i = 0; i < 12; i++) begin
      if (i == 6) wr(ADDR_STATE_AMP, 8'h05);
      kick = ~kick;
      rnd = nx(rnd);
      demod_data = rnd[0];
      cyc();
      chk(8'(i < 6 ? tx_mod_data : data_line_out), 8'(i < 6 ? data_line_in : demod_data));
    end
    $display("states done");
    // Sync transmit, K=1 and S=2: half period 16
    wr(ADDR_BITCLK_SCALE, 8'h00);
    wr(ADDR_REF_DIV, 8'h81);
    wr(ADDR_STATE_AMP, 8'h1f);
    gap(1'b0, 32);
    // Sync receive, one tick a cycle, sixteen ticks a bit
    wr(ADDR_BITCLK_SCALE, 8'h0e);
    wr(ADDR_STATE_AMP, 8'h0d);
    // Each new level must come out on the pin and reach the host
    for (int b = 0; b < 2; b++) begin
      demod_data = b[0];
      gap(1'b0, 16);
      chk(8'(rx_bit), 8'(b));
    end
    wr(ADDR_CHFILT_DIV, 8'h45);
    gap(1'b1, 5);
    $display("data port done");
    end_of_test();
  end
endmodule
bind tmdp_core tmdp_chk tmdp_chk_inst (.*);
`default_nettype wire
